// ---- spc_pkg.sv ----
// shared constants and types of the serial port pin control block
package spc_pkg;

	// ==========================================================
	// register access
	localparam logic [7:0] SPC_PCR_SUBADDR = 8'h0E; // subbank address of the pin control register

	// ==========================================================
	// field positions in the pin control register
	localparam int SPC_BIT_TX_GPIO   = 13;
	localparam int SPC_BIT_RX_GPIO   = 12;
	localparam int SPC_BIT_FSX_MODE  = 11;
	localparam int SPC_BIT_FSR_MODE  = 10;
	localparam int SPC_BIT_TX_CLOCK_PIN_MODE = 9;
	localparam int SPC_BIT_RX_CLOCK_PIN_MODE = 8;
	localparam int SPC_BIT_REF_EXT   = 7;
	localparam int SPC_BIT_REF_CLOCK_PIN_STATUS = 6;
	localparam int SPC_BIT_DATA_OUT_PIN_STATUS   = 5;
	localparam int SPC_BIT_DATA_IN_PIN_STATUS   = 4;
	localparam int SPC_BIT_FSX_POL   = 3;
	localparam int SPC_BIT_FSR_POL   = 2;
	localparam int SPC_BIT_TX_CLOCK_PIN_POL  = 1;
	localparam int SPC_BIT_RX_CLOCK_PIN_POL  = 0;

	// ==========================================================
	// types
	typedef struct packed {
		logic tx_gpio_enable;
		logic rx_gpio_enable;
		logic tx_fsync_mode;
		logic rx_fsync_mode;
		logic tx_clock_mode;
		logic rx_clock_mode;
		logic generator_ref_extended;
		logic data_out_pin_status;
		logic tx_fsync_polarity;
		logic rx_fsync_polarity;
		logic tx_clock_polarity;
		logic rx_clock_polarity;
	} spc_pcr_t;

	typedef struct packed {
		logic out; // level driven onto the pin
		logic oe;  // high while the pin is driven
	} spc_pin_t;

	typedef struct packed {
		logic s1; // first synchroniser stage
		logic s2; // second synchroniser stage
		logic s3; // delayed copy for edge finding
	} spc_sync_state_t;

	typedef struct packed {
		spc_pcr_t    serial_pin_control;
		logic [15:0] rdata;
		spc_pin_t    dx;
		spc_pin_t    tx_fsync_pin;
		spc_pin_t    tx_clock_pin;
		spc_pin_t    rx_fsync_pin;
		spc_pin_t    rx_clock_pin;
		logic        tx_shift;
		logic        rx_sample;
		logic        tx_fs;
		logic        rx_fs;
		logic        rx_data;
		logic        ref_strobe;
		logic        prev_tx_clk;
		logic        prev_rx_clk;
		logic        prev_ref;
	} spc_state_t;

	// ==========================================================
	// reset values
	localparam spc_pcr_t        SPC_PCR_RESET   = '0;
	localparam spc_sync_state_t SPC_SYNC_RESET  = '0;
	localparam spc_state_t      SPC_STATE_RESET = '0;

endpackage : spc_pkg

// ---- spc_pin_sync.sv ----
// two-stage synchroniser with edge finding for one serial port pin
`timescale 1ns/100ps

module spc_pin_sync
	import spc_pkg::*;
(
	input  wire logic sys_clk, // system clock
	input  wire logic rstn,    // synchronous reset, active low
	input  wire logic pin_in,  // raw pin level
	output logic      level,   // synchronised level
	output logic      rise,    // one-cycle pulse on a rising edge
	output logic      fall     // one-cycle pulse on a falling edge
);

	spc_sync_state_t cur;
	spc_sync_state_t next_cur;

	// ==========================================================
	// shift chain; s1 feeds only s2
	always_comb begin
		next_cur    = cur;
		next_cur.s1 = pin_in;
		next_cur.s2 = cur.s1;
		next_cur.s3 = cur.s2;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cur <= SPC_SYNC_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// edges are seen only between the second and third stage
	assign level = cur.s2;
	assign rise  = cur.s2 & ~cur.s3;
	assign fall  = ~cur.s2 & cur.s3;

endmodule : spc_pin_sync

// ---- spc_pin_control.sv ----
// pin control logic of the buffered serial port: directions, sources, polarity, gpio
`timescale 1ns/100ps

// Overview of operation
// - tx gpio enable honoured only in transmitter reset
// - tx gpio: data out, fsync, clock become gpio
// - rx gpio enable honoured only in receiver reset
// - rx gpio: data in, ref, fsync, clock gpio
// - ref pin use set by reset and enable
// - tx fsync mode picks external pin or internal source, generator or buffer copy
// - rx fsync mode: input, or generator fsync, driven out while clock sync is clear
// - tx clock mode: external input or generator output
// - spi slave: master drives tx clock, rx follows
// - spi master: drives tx clock, rx uses it
// - outside spi: rx clock mode sets rx pin direction
// - loopback with rx clock mode clear: rx follows tx, rx pin floats
// - extended bit picks generator reference group
// - bit 6 mirrors ref pin as gpio input
// - bit 5 drives data out pin as gpio
// - bit 4 mirrors data in pin as gpio
// - fsync polarity zero high, one low
// - tx data on rising or falling clock edge
// - rx sample on falling or rising clock edge
// - top two bits reserved, no pin effect
// - four generator sources from two mode bits
module spc_pin_control
	import spc_pkg::*;
(
	input  wire logic        sys_clk,              // system clock, 200 MHz
	input  wire logic        rstn,                 // synchronous reset, active low
	input  wire logic        reg_write,            // one-cycle write strobe
	input  wire logic [7:0]  reg_subaddr,          // subbank address of the access
	input  wire logic [15:0] reg_wdata,            // write data
	output logic      [15:0] reg_rdata,            // pin control register read value
	input  wire logic        transmitter_reset_n,  // transmitter out of reset
	input  wire logic        receiver_reset_n,     // receiver out of reset
	input  wire logic        digital_loopback,     // loop-back mode
	input  wire logic [1:0]  clock_stop_field,     // nonzero selects spi mode
	input  wire logic        generator_clock_sync, // generator clock synchronisation
	input  wire logic        generator_fsync_mode, // generator drives tx fsync
	input  wire logic        generator_clock_mode, // generator clock source select
	input  wire logic        gen_clock,            // generator clock level
	input  wire logic        gen_fsync,            // generator frame sync, active high
	input  wire logic        tx_copy_fsync,        // fsync from transmit buffer copy
	input  wire logic        tx_data,              // transmitter serial bit
	input  wire logic        tx_data_en,           // transmitter drives data out
	input  wire logic        serial_data_in_pin,   // data in pin
	input  wire logic        external_ref_clock_pin, // reference clock pin
	input  wire logic        tx_fsync_pin_in,      // tx fsync pin level
	input  wire logic        tx_clock_pin_in,      // tx clock pin level
	input  wire logic        rx_fsync_pin_in,      // rx fsync pin level
	input  wire logic        rx_clock_pin_in,      // rx clock pin level
	output logic             serial_data_out_pin,  // data out pin level
	output logic             serial_data_out_oe,   // data out pin enable
	output logic             tx_fsync_pin_out,     // tx fsync pin level
	output logic             tx_fsync_pin_oe,      // tx fsync pin enable
	output logic             tx_clock_pin_out,     // tx clock pin level
	output logic             tx_clock_pin_oe,      // tx clock pin enable
	output logic             rx_fsync_pin_out,     // rx fsync pin level
	output logic             rx_fsync_pin_oe,      // rx fsync pin enable
	output logic             rx_clock_pin_out,     // rx clock pin level
	output logic             rx_clock_pin_oe,      // rx clock pin enable
	output logic             tx_shift_strobe,      // pulse: shift next tx bit
	output logic             tx_fsync,             // tx frame sync, active high
	output logic             rx_sample_strobe,     // pulse: sample rx bit
	output logic             rx_fsync,             // rx frame sync, active high
	output logic             rx_data,              // rx serial bit
	output logic             srg_ref_strobe        // pulse: generator reference edge
);

	spc_state_t cur;
	spc_state_t next_cur;

	// ==========================================================
	// pin synchronisers
	logic dr_lvl;
	logic external_ref_clock_pin_lvl;
	logic fsx_lvl;
	logic tx_clock_pin_lvl;
	logic fsr_lvl;
	logic rx_clock_pin_lvl;

	spc_pin_sync u_sync_dr (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.pin_in  (serial_data_in_pin),
		.level   (dr_lvl),
		.rise    (),
		.fall    ()
	);

	spc_pin_sync u_sync_external_ref_clock_pin (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.pin_in  (external_ref_clock_pin),
		.level   (external_ref_clock_pin_lvl),
		.rise    (),
		.fall    ()
	);

	spc_pin_sync u_sync_fsx (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.pin_in  (tx_fsync_pin_in),
		.level   (fsx_lvl),
		.rise    (),
		.fall    ()
	);

	spc_pin_sync u_sync_tx_clock_pin (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.pin_in  (tx_clock_pin_in),
		.level   (tx_clock_pin_lvl),
		.rise    (),
		.fall    ()
	);

	spc_pin_sync u_sync_fsr (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.pin_in  (rx_fsync_pin_in),
		.level   (fsr_lvl),
		.rise    (),
		.fall    ()
	);

	spc_pin_sync u_sync_rx_clock_pin (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.pin_in  (rx_clock_pin_in),
		.level   (rx_clock_pin_lvl),
		.rise    (),
		.fall    ()
	);

	// ==========================================================
	// mode decode
	logic tx_gpio;
	logic rx_gpio;
	logic spi_mode;
	logic rx_follows_tx;
	logic tx_clk_lvl;
	logic rx_clk_lvl;
	logic tx_rise;
	logic tx_fall;
	logic rx_rise;
	logic rx_fall;
	logic ref_lvl;
	logic ref_cpu;
	logic pcr_hit;

	// gpio takes effect only while the matching half is held in reset
	assign tx_gpio  = ~transmitter_reset_n & cur.serial_pin_control.tx_gpio_enable;
	assign rx_gpio  = ~receiver_reset_n & cur.serial_pin_control.rx_gpio_enable;
	assign spi_mode = |clock_stop_field;
	assign pcr_hit  = reg_write && (reg_subaddr == SPC_PCR_SUBADDR);

	// spi in either role and loop-back with rx clock mode clear run rx from tx
	assign rx_follows_tx = spi_mode | (digital_loopback & ~cur.serial_pin_control.rx_clock_mode);

	// internal clock levels and their edges
	assign tx_clk_lvl = cur.serial_pin_control.tx_clock_mode ? gen_clock : tx_clock_pin_lvl;
	assign rx_clk_lvl = rx_follows_tx ? tx_clk_lvl
		: (cur.serial_pin_control.rx_clock_mode ? gen_clock : rx_clock_pin_lvl);
	assign tx_rise = tx_clk_lvl & ~cur.prev_tx_clk;
	assign tx_fall = ~tx_clk_lvl & cur.prev_tx_clk;
	assign rx_rise = rx_clk_lvl & ~cur.prev_rx_clk;
	assign rx_fall = ~rx_clk_lvl & cur.prev_rx_clk;

	// generator reference: the ref pin counts only while not a gpio input
	always_comb begin
		ref_cpu = 1'b0;
		unique case ({cur.serial_pin_control.generator_ref_extended, generator_clock_mode})
			2'b00: ref_lvl = external_ref_clock_pin_lvl & ~rx_gpio;
			2'b01: begin
				ref_lvl = 1'b0;
				ref_cpu = 1'b1;
			end
			2'b10: ref_lvl = rx_clock_pin_lvl;
			2'b11: ref_lvl = tx_clock_pin_lvl;
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		next_cur = cur;

		// register write; reserved bits and status bits 6 and 4 are not stored
		if (pcr_hit) begin
			next_cur.serial_pin_control.tx_gpio_enable         = reg_wdata[SPC_BIT_TX_GPIO];
			next_cur.serial_pin_control.rx_gpio_enable         = reg_wdata[SPC_BIT_RX_GPIO];
			next_cur.serial_pin_control.tx_fsync_mode          = reg_wdata[SPC_BIT_FSX_MODE];
			next_cur.serial_pin_control.rx_fsync_mode          = reg_wdata[SPC_BIT_FSR_MODE];
			next_cur.serial_pin_control.tx_clock_mode          = reg_wdata[SPC_BIT_TX_CLOCK_PIN_MODE];
			next_cur.serial_pin_control.rx_clock_mode          = reg_wdata[SPC_BIT_RX_CLOCK_PIN_MODE];
			next_cur.serial_pin_control.generator_ref_extended = reg_wdata[SPC_BIT_REF_EXT];
			next_cur.serial_pin_control.data_out_pin_status    = reg_wdata[SPC_BIT_DATA_OUT_PIN_STATUS];
			next_cur.serial_pin_control.tx_fsync_polarity      = reg_wdata[SPC_BIT_FSX_POL];
			next_cur.serial_pin_control.rx_fsync_polarity      = reg_wdata[SPC_BIT_FSR_POL];
			next_cur.serial_pin_control.tx_clock_polarity      = reg_wdata[SPC_BIT_TX_CLOCK_PIN_POL];
			next_cur.serial_pin_control.rx_clock_polarity      = reg_wdata[SPC_BIT_RX_CLOCK_PIN_POL];
		end

		// read value; bits 15 and 14 stay zero
		next_cur.rdata = 16'h0000;
		next_cur.rdata[SPC_BIT_TX_GPIO]   = cur.serial_pin_control.tx_gpio_enable;
		next_cur.rdata[SPC_BIT_RX_GPIO]   = cur.serial_pin_control.rx_gpio_enable;
		next_cur.rdata[SPC_BIT_FSX_MODE]  = cur.serial_pin_control.tx_fsync_mode;
		next_cur.rdata[SPC_BIT_FSR_MODE]  = cur.serial_pin_control.rx_fsync_mode;
		next_cur.rdata[SPC_BIT_TX_CLOCK_PIN_MODE] = cur.serial_pin_control.tx_clock_mode;
		next_cur.rdata[SPC_BIT_RX_CLOCK_PIN_MODE] = cur.serial_pin_control.rx_clock_mode;
		next_cur.rdata[SPC_BIT_REF_EXT]   = cur.serial_pin_control.generator_ref_extended;
		next_cur.rdata[SPC_BIT_REF_CLOCK_PIN_STATUS] = rx_gpio & external_ref_clock_pin_lvl;
		next_cur.rdata[SPC_BIT_DATA_OUT_PIN_STATUS]   = cur.serial_pin_control.data_out_pin_status;
		next_cur.rdata[SPC_BIT_DATA_IN_PIN_STATUS]   = rx_gpio & dr_lvl;
		// a gpio input pin reads its level in place of the polarity bit
		next_cur.rdata[SPC_BIT_FSX_POL]  = (tx_gpio && !cur.serial_pin_control.tx_fsync_mode)
			? fsx_lvl : cur.serial_pin_control.tx_fsync_polarity;
		next_cur.rdata[SPC_BIT_FSR_POL]  = (rx_gpio && !cur.serial_pin_control.rx_fsync_mode)
			? fsr_lvl : cur.serial_pin_control.rx_fsync_polarity;
		next_cur.rdata[SPC_BIT_TX_CLOCK_PIN_POL] = (tx_gpio && !cur.serial_pin_control.tx_clock_mode)
			? tx_clock_pin_lvl : cur.serial_pin_control.tx_clock_polarity;
		next_cur.rdata[SPC_BIT_RX_CLOCK_PIN_POL] = (rx_gpio && !cur.serial_pin_control.rx_clock_mode)
			? rx_clock_pin_lvl : cur.serial_pin_control.rx_clock_polarity;

		// edge history
		next_cur.prev_tx_clk = tx_clk_lvl;
		next_cur.prev_rx_clk = rx_clk_lvl;
		next_cur.prev_ref    = ref_lvl;
		next_cur.ref_strobe  = ref_cpu | (ref_lvl & ~cur.prev_ref);

		// transmit side
		if (tx_gpio) begin
			// data out is always driven with bit 5; mode bits give fsync and clock direction, polarity bits their level
			next_cur.dx.out   = cur.serial_pin_control.data_out_pin_status;
			next_cur.dx.oe    = 1'b1;
			next_cur.tx_fsync_pin.out  = cur.serial_pin_control.tx_fsync_polarity;
			next_cur.tx_fsync_pin.oe   = cur.serial_pin_control.tx_fsync_mode;
			next_cur.tx_clock_pin.out = cur.serial_pin_control.tx_clock_polarity;
			next_cur.tx_clock_pin.oe  = cur.serial_pin_control.tx_clock_mode;
			next_cur.tx_shift = 1'b0;
			next_cur.tx_fs    = 1'b0;
		end else begin
			next_cur.dx.out   = tx_data;
			next_cur.dx.oe    = tx_data_en;
			// master drives the generator clock out; slave takes the pin
			next_cur.tx_clock_pin.out = gen_clock;
			next_cur.tx_clock_pin.oe  = cur.serial_pin_control.tx_clock_mode;
			next_cur.tx_shift = cur.serial_pin_control.tx_clock_polarity ? tx_fall : tx_rise;
			if (cur.serial_pin_control.tx_fsync_mode) begin
				next_cur.tx_fs   = generator_fsync_mode ? gen_fsync : tx_copy_fsync;
				next_cur.tx_fsync_pin.out = next_cur.tx_fs ^ cur.serial_pin_control.tx_fsync_polarity;
				next_cur.tx_fsync_pin.oe  = 1'b1;
			end else begin
				next_cur.tx_fs   = fsx_lvl ^ cur.serial_pin_control.tx_fsync_polarity;
				next_cur.tx_fsync_pin.out = 1'b0;
				next_cur.tx_fsync_pin.oe  = 1'b0;
			end
		end

		// receive side
		if (rx_gpio) begin
			next_cur.rx_fsync_pin.out   = cur.serial_pin_control.rx_fsync_polarity;
			next_cur.rx_fsync_pin.oe    = cur.serial_pin_control.rx_fsync_mode;
			next_cur.rx_clock_pin.out  = cur.serial_pin_control.rx_clock_polarity;
			next_cur.rx_clock_pin.oe   = cur.serial_pin_control.rx_clock_mode;
			next_cur.rx_sample = 1'b0;
			next_cur.rx_fs     = 1'b0;
			next_cur.rx_data   = 1'b0;
		end else begin
			next_cur.rx_data   = dr_lvl;
			next_cur.rx_sample = cur.serial_pin_control.rx_clock_polarity ? rx_rise : rx_fall;
			// rx clock pin floats whenever rx runs from the tx clock
			next_cur.rx_clock_pin.out  = gen_clock;
			next_cur.rx_clock_pin.oe   = cur.serial_pin_control.rx_clock_mode & ~spi_mode;
			if (cur.serial_pin_control.rx_fsync_mode) begin
				next_cur.rx_fs   = gen_fsync;
				next_cur.rx_fsync_pin.out = gen_fsync ^ cur.serial_pin_control.rx_fsync_polarity;
				next_cur.rx_fsync_pin.oe  = ~generator_clock_sync;
			end else begin
				next_cur.rx_fs   = fsr_lvl ^ cur.serial_pin_control.rx_fsync_polarity;
				next_cur.rx_fsync_pin.out = 1'b0;
				next_cur.rx_fsync_pin.oe  = 1'b0;
			end
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			cur <= SPC_STATE_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// ==========================================================
	// outputs, all straight from the state register
	assign reg_rdata           = cur.rdata;
	assign serial_data_out_pin = cur.dx.out;
	assign serial_data_out_oe  = cur.dx.oe;
	assign tx_fsync_pin_out    = cur.tx_fsync_pin.out;
	assign tx_fsync_pin_oe     = cur.tx_fsync_pin.oe;
	assign tx_clock_pin_out    = cur.tx_clock_pin.out;
	assign tx_clock_pin_oe     = cur.tx_clock_pin.oe;
	assign rx_fsync_pin_out    = cur.rx_fsync_pin.out;
	assign rx_fsync_pin_oe     = cur.rx_fsync_pin.oe;
	assign rx_clock_pin_out    = cur.rx_clock_pin.out;
	assign rx_clock_pin_oe     = cur.rx_clock_pin.oe;
	assign tx_shift_strobe     = cur.tx_shift;
	assign tx_fsync            = cur.tx_fs;
	assign rx_sample_strobe    = cur.rx_sample;
	assign rx_fsync            = cur.rx_fs;
	assign rx_data             = cur.rx_data;
	assign srg_ref_strobe      = cur.ref_strobe;

	// ==========================================================
	// checks
	AST_TX_RUN_SERIAL: assert property (@(posedge sys_clk) disable iff (!rstn)
		transmitter_reset_n |=> serial_data_out_pin == $past(tx_data))
		else $error("data out not serial while transmitter runs");

	AST_TX_GPIO_DRIVE: assert property (@(posedge sys_clk) disable iff (!rstn)
		(tx_gpio && !pcr_hit) |=> serial_data_out_oe && !tx_shift_strobe
			&& (serial_data_out_pin == reg_rdata[SPC_BIT_DATA_OUT_PIN_STATUS]))
		else $error("gpio data out level wrong");

	AST_RX_GPIO_QUIET: assert property (@(posedge sys_clk) disable iff (!rstn)
		rx_gpio |=> !rx_sample_strobe && !rx_fsync && !rx_data)
		else $error("receive activity during rx gpio");

	AST_DR_STATUS: assert property (@(posedge sys_clk) disable iff (!rstn)
		rx_gpio |=> reg_rdata[SPC_BIT_DATA_IN_PIN_STATUS] == $past(dr_lvl))
		else $error("data in status does not follow pin");

	AST_FSR_DIR: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!rx_gpio && cur.serial_pin_control.rx_fsync_mode) |=> rx_fsync_pin_oe == !$past(generator_clock_sync))
		else $error("rx fsync direction wrong");

	AST_RX_CLOCK_PIN_FLOAT: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!rx_gpio && digital_loopback && !cur.serial_pin_control.rx_clock_mode) |=> !rx_clock_pin_oe)
		else $error("rx clock pin driven in loop-back");

	AST_TX_CLOCK_PIN_DIR: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!tx_gpio && !pcr_hit) |=> tx_clock_pin_oe == reg_rdata[SPC_BIT_TX_CLOCK_PIN_MODE])
		else $error("tx clock direction wrong");

	AST_TX_EDGE: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!tx_gpio && !cur.serial_pin_control.tx_clock_polarity && tx_fall) |=> !tx_shift_strobe)
		else $error("tx shift on wrong edge");

	AST_REF_CPU: assert property (@(posedge sys_clk) disable iff (!rstn)
		(!cur.serial_pin_control.generator_ref_extended && generator_clock_mode) |=> srg_ref_strobe)
		else $error("cpu reference strobe missing");

	AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
		##1 reg_rdata[15:14] == 2'b00)
		else $error("reserved bits read nonzero");

endmodule : spc_pin_control

// ---- spc_peer.sv ----
// serial peer model: link clock, frame sync, data and reference levels
`timescale 1ns/100ps

module spc_peer (
	input  wire logic run,      // link clock runs while high
	input  wire logic fs_lvl,   // frame sync level to present
	input  wire logic dat_lvl,  // data level to present
	input  wire logic ref_lvl,  // reference clock level to present
	output logic      link_clk, // serial clock, low outside frames
	output logic      fs_pin,   // frame sync pin
	output logic      dat_pin,  // data pin
	output logic      ref_pin   // reference clock pin
);
	// ==========================================================
	// 125 ns link clock, still between frames; as spi master it drives the slave clock
	// the 1 ns offset keeps its edges clear of the system clock edges
	initial begin
		link_clk = 1'b0;
		#1;
		forever begin
			#62.5;
			link_clk = run ? ~link_clk : 1'b0;
		end
	end

	// ==========================================================
	// levels set by the bench; the reference pin also follows the link clock
	assign fs_pin  = fs_lvl;
	assign dat_pin = dat_lvl;
	assign ref_pin = ref_lvl ^ link_clk;
endmodule : spc_peer

// ---- tb_top.sv ----
// self-checking bench of the serial port pin control block
`timescale 1ns/100ps

module tb_top;
	import spc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        reg_write = 1'b0;
	logic [7:0]  reg_subaddr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic [12:0] ctl = 13'h0000; // control and same-domain inputs
	logic        run = 1'b0, fs_lvl = 1'b0, dat_lvl = 1'b1, ref_lvl = 1'b0, quiet = 1'b0;
	logic        link_clk, fs_pin, dat_pin, ref_pin;
	wire  [9:0]  pin;  // pin levels and enables, dx down to rx_clock_pin
	wire  [5:0]  sig;  // tx shift, tx fs, rx sample, rx fs, rx data, ref
	int          bad_count = 0, cmp_count = 0, n_tx = 0, n_rx = 0, n_rf = 0;

	// ==========================================================
	// wire levels from all drivers; quiet holds the rx clock line low
	wire fsx_w  = pin[6] ? pin[7] : fs_pin;
	wire tx_clock_pin_w = pin[4] ? pin[5] : link_clk;
	wire fsr_w  = pin[2] ? pin[3] : fs_pin;
	wire rx_clock_pin_w = pin[0] ? pin[1] : (link_clk & ~quiet);

	always #2.5 sys_clk = ~sys_clk;

	spc_peer peer_u (.run, .fs_lvl, .dat_lvl, .ref_lvl, .link_clk, .fs_pin, .dat_pin, .ref_pin);

	spc_pin_control dut_u (
		.sys_clk, .rstn, .reg_write, .reg_subaddr, .reg_wdata, .reg_rdata,
		.transmitter_reset_n(ctl[0]), .receiver_reset_n(ctl[1]), .digital_loopback(ctl[2]),
		.clock_stop_field(ctl[4:3]), .generator_clock_sync(ctl[5]),
		.generator_fsync_mode(ctl[6]), .generator_clock_mode(ctl[7]), .gen_clock(ctl[8]),
		.gen_fsync(ctl[9]), .tx_copy_fsync(ctl[10]), .tx_data(ctl[11]), .tx_data_en(ctl[12]),
		.serial_data_in_pin(dat_pin), .external_ref_clock_pin(ref_pin),
		.tx_fsync_pin_in(fsx_w), .tx_clock_pin_in(tx_clock_pin_w),
		.rx_fsync_pin_in(fsr_w), .rx_clock_pin_in(rx_clock_pin_w),
		.serial_data_out_pin(pin[9]), .serial_data_out_oe(pin[8]),
		.tx_fsync_pin_out(pin[7]), .tx_fsync_pin_oe(pin[6]),
		.tx_clock_pin_out(pin[5]), .tx_clock_pin_oe(pin[4]),
		.rx_fsync_pin_out(pin[3]), .rx_fsync_pin_oe(pin[2]),
		.rx_clock_pin_out(pin[1]), .rx_clock_pin_oe(pin[0]),
		.tx_shift_strobe(sig[5]), .tx_fsync(sig[4]), .rx_sample_strobe(sig[3]),
		.rx_fsync(sig[2]), .rx_data(sig[1]), .srg_ref_strobe(sig[0])
	);

	// ==========================================================
	// strobe counters
	always @(posedge sys_clk) begin
		n_tx = n_tx + int'(sig[5] === 1'b1);
		n_rx = n_rx + int'(sig[3] === 1'b1);
		n_rf = n_rf + int'(sig[0] === 1'b1);
	end

	// ==========================================================
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		step(1);
		reg_subaddr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		step(1);
		reg_write = 1'b0;
		step(4);
	endtask : wreg

	// one frame of k link clocks, counts taken while the clock is still high
	task automatic frame(input int k, input int et, input int er, input int ef);
		step(4);
		n_tx = 0;
		n_rx = 0;
		n_rf = 0;
		run = 1'b1;
		repeat (k) @(posedge link_clk);
		step(6);
		chk("tx strobes", 16'(et), 16'(n_tx));
		chk("rx strobes", 16'(er), 16'(n_rx));
		chk("ref strobes", 16'(ef), 16'(n_rf));
		run = 1'b0;
		step(30);
	endtask : frame

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// ==========================================================
	// watchdog against a hang
	initial begin
		#100000;
		bad_count++;
		finish_test();
	end

	// ==========================================================
	// test sequence
	initial begin
		step(8);
		rstn = 1'b1;
		step(2);
		chk("reset", 16'h0000, reg_rdata);
		// both sides in reset: full gpio
		wreg(SPC_PCR_SUBADDR, 16'hFFFF);
		chk("gpio read", 16'h3FBF, reg_rdata);
		chk("gpio pins", 16'h03FF, 16'(pin));
		// the rx clock pin, now driven high, gives the selected reference one edge
		chk("gpio strobes", 16'h0001, 16'(sig));
		wreg(8'h0D, 16'h0000);
		chk("other address", 16'h3FBF, reg_rdata);
		wreg(SPC_PCR_SUBADDR, 16'h3000);
		chk("gpio inputs", 16'h3010, reg_rdata);
		chk("gpio dirs", 16'h0100, 16'(pin));
		// the toggling reference pin must not reach the generator as a gpio input
		frame(4, 0, 0, 0);
		ref_lvl = 1'b1;
		dat_lvl = 1'b0;
		fs_lvl = 1'b1;
		step(6);
		chk("gpio levels", 16'h304C, reg_rdata);
		ref_lvl = 1'b0;
		// running: gpio enables ignored, clock polarity sets the edge
		ctl = 13'h1003;
		for (int p = 0; p < 2; p++) begin
			wreg(SPC_PCR_SUBADDR, 16'h3020 | 16'(3 * p));
			chk("serial read", 16'h3020 | 16'(3 * p), reg_rdata);
			chk("serial dirs", 16'h0100, 16'(pin & 10'h355));
			frame(4, p ? 3 : 4, p ? 4 : 3, 4);
		end
		// generator tx clock and reference selection
		ctl = 13'h0083;
		wreg(SPC_PCR_SUBADDR, 16'h0280);
		chk("tx_clock_pin low", 16'h0010, 16'(pin & 10'h030));
		ctl[8] = 1'b1;
		step(3);
		chk("tx_clock_pin high", 16'h0030, 16'(pin & 10'h030));
		ctl[8] = 1'b0;
		frame(4, 0, 3, 0);
		ctl[7] = 1'b0;
		frame(4, 0, 3, 4);
		ctl[7] = 1'b1;
		wreg(SPC_PCR_SUBADDR, 16'h0200);
		chk("cpu reference", 16'h0001, 16'(sig[0]));
		// loopback and spi with the rx clock line held quiet
		quiet = 1'b1;
		ctl = 13'h0007;
		wreg(SPC_PCR_SUBADDR, 16'h0000);
		chk("loop dirs", 16'h0000, 16'(pin & 10'h155));
		frame(4, 4, 3, 4);
		ctl = 13'h000B;
		frame(4, 4, 3, 4);
		wreg(SPC_PCR_SUBADDR, 16'h0300);
		chk("spi master", 16'h0010, 16'(pin & 10'h155));
		quiet = 1'b0;
		// frame sync polarity and sources
		ctl = 13'h0003;
		dat_lvl = 1'b1;
		for (int p = 0; p < 2; p++) begin
			wreg(SPC_PCR_SUBADDR, p ? 16'h000C : 16'h0000);
			chk("fsync level", p ? 16'h0000 : 16'h0003, 16'({sig[4], sig[2]}));
		end
		chk("rx data", 16'h0001, 16'(sig[1]));
		ctl = 13'h0243;
		wreg(SPC_PCR_SUBADDR, 16'h0C08);
		chk("fsync gen", 16'h0044, 16'(pin & 10'h0C4));
		ctl = 13'h0223;
		step(3);
		chk("fsync copy", 16'h00C0, 16'(pin & 10'h0C4));
		chk("rx fsync out", 16'h0001, 16'(pin[3]));
		finish_test();
	end
endmodule : tb_top
